// file: rtl/io_event_pkg.sv
// constants, register map and timing for the configurable io event port
package io_event_pkg;
  // apb register byte offsets
  localparam logic [7:0] ADDR_PARAM = 8'h00;
  localparam logic [7:0] ADDR_OUTDATA = 8'h04;
  localparam logic [7:0] ADDR_INDATA = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_QUALITY = 8'h14;
  // parameter word field positions: byte*8 + bit
  localparam int BIT_FUNCTION = 0;
  localparam int BIT_ACTIVATION = 1;
  localparam int BIT_EN_POS = 11;
  localparam int BIT_EN_SPEED = 12;
  localparam int BIT_EN_WARN = 13;
  localparam int BIT_EN_ERR = 14;
  localparam int BIT_EN_DIRECT = 16;
  localparam int BIT_EN_DEVERR = 17;
  localparam int POS_INFUNC = 24;
  // parameter reset value: output mode, active high, all events off
  localparam logic [31:0] PARAM_RESET = 32'h0000_0003;
  localparam logic [7:0] QUALITY_WARN_RESET = 8'h50;
  localparam logic [7:0] QUALITY_ERR_RESET = 8'h28;
  // irq status bits
  localparam int IRQ_PIN_RISE = 0;
  localparam int IRQ_TRIGGER = 1;
  localparam int IRQ_VALID = 2;
  localparam int IRQ_WIDTH = 3;
  // input function codes
  localparam logic [1:0] FUNC_NONE = 2'h0;
  localparam logic [1:0] FUNC_STOPSTART = 2'h1;
  localparam logic [1:0] FUNC_TEACH = 2'h2;
  localparam logic [1:0] FUNC_RESET = 2'h3;
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int LASER_SETTLE_US = 10_000;
  localparam int LASER_SETTLE_CYC = LASER_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int MOTOR_SPINUP_MS = 3000;
  localparam int MOTOR_SPINUP_CYC = MOTOR_SPINUP_MS * (CLK_HZ / 1000);
endpackage

// file: rtl/settle_timer.sv
// down counter that holds measurement values invalid for a settle time
`timescale 1ns/1ps
module settle_timer (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic [31:0] load_in,
  output logic busy_out
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;

  // load on start, count down to zero
  always_comb
  begin
    cnt_d = cnt_q;
    if (start_in)
      cnt_d = load_in;
    else if (cnt_q != 32'h0000_0000)
      cnt_d = cnt_q - 32'h0000_0001;
  end

  // register the count
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      cnt_q <= 32'h0000_0000;
    else if (ce_in)
      cnt_q <= cnt_d;
  end

  assign busy_out = (cnt_q != 32'h0000_0000);
endmodule

// file: rtl/io_event_port.sv
// configurable io event port with apb register access
//
// Behaviour
// R01 - output is OR of enabled events
// R02 - position invalid event, enable bit 1.3
// R03 - speed invalid event, enable bit 1.4
// R04 - quality below warning threshold, bit 1.5
// R05 - quality below error threshold, separate bit
// R06 - direct control via output data bit
// R07 - device fault event, enable bit 2.1
// R08 - input function code 0..3, default 0
// R09 - function 0 reports external state only
// R10 - input data bit reports active state
// R11 - output data bit needs parameter enable
// R12 - laser restart: valid after 10 ms
// R13 - standby wake: valid after motor spinup
// R14 - parameter bit 0.0 selects in/out
// R15 - parameter bit 0.1 selects polarity
// R16 - input functions fire on edges
// R17 - pin level registered through polarity
`timescale 1ns/1ps
module io_event_port #(
  parameter int unsigned LASER_CYC = io_event_pkg::LASER_SETTLE_CYC,
  parameter int unsigned MOTOR_CYC = io_event_pkg::MOTOR_SPINUP_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_out,
  input wire logic pos_raw_invalid_in,
  input wire logic speed_raw_invalid_in,
  input wire logic [7:0] quality_in,
  input wire logic device_fault_in,
  input wire logic laser_on_in,
  input wire logic standby_wake_in,
  output logic meas_stop_out,
  output logic teach_preset_out,
  output logic reset_preset_out,
  output logic meas_valid_out,
  output logic irq_out
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACCESS = 3'b010,
    ST_DONE = 3'b100
  } apb_state_t;

  // true when a parameter bit is set
  function automatic logic pbit(input logic [31:0] p, input int idx);
    pbit = p[idx];
  endfunction

  apb_state_t st_q, st_d;
  logic [31:0] param_q, param_d;
  logic outdata_q, outdata_d;
  logic [15:0] qual_q, qual_d;
  logic [2:0] irq_st_q, irq_st_d;
  logic [2:0] irq_mask_q, irq_mask_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic pready_q, pready_d;
  logic pin_prev_q, pin_prev_d;
  logic pin_q, pin_d, oe_q, oe_d, state_q, state_d;
  logic stop_q, stop_d, teach_q, teach_d, rst_p_q, rst_p_d;
  logic stopped_q, stopped_d, valid_q, valid_d, irq_q, irq_d;
  logic event_any, active_edge, restart, laser_busy, motor_busy;
  logic pos_inv, speed_inv, setup, wr_ok, rd_status;
  logic [1:0] infunc;

  // hold values invalid after laser restart or standby wake
  settle_timer u_laser (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(restart), // R12
    .load_in(32'(LASER_CYC)),
    .busy_out(laser_busy)
  );
  settle_timer u_motor (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(standby_wake_in), // R13
    .load_in(32'(MOTOR_CYC)),
    .busy_out(motor_busy)
  );

  // measurement validity and event sources
  // the start cycle itself counts as invalid, so no stale valid slips out
  always_comb
  begin
    restart = laser_on_in && !laser_busy;
    pos_inv = pos_raw_invalid_in || restart || standby_wake_in // R12 R13
      || laser_busy || motor_busy || stopped_q;
    speed_inv = speed_raw_invalid_in || restart || standby_wake_in
      || laser_busy || motor_busy || stopped_q;
    infunc = param_q[io_event_pkg::POS_INFUNC +: 2]; // R08
    event_any = (pbit(param_q, io_event_pkg::BIT_EN_POS) && pos_inv) // R01 R02
      || (pbit(param_q, io_event_pkg::BIT_EN_SPEED) && speed_inv) // R03
      || (pbit(param_q, io_event_pkg::BIT_EN_WARN) && quality_in < qual_q[7:0]) // R04
      || (pbit(param_q, io_event_pkg::BIT_EN_ERR) && quality_in < qual_q[15:8]) // R05
      || (pbit(param_q, io_event_pkg::BIT_EN_DIRECT) && outdata_q) // R06 R11
      || (pbit(param_q, io_event_pkg::BIT_EN_DEVERR) && device_fault_in); // R07
    // active edge of the input per polarity
    active_edge = pbit(param_q, io_event_pkg::BIT_ACTIVATION)
      ? (pin_in && !pin_prev_q) : (!pin_in && pin_prev_q); // R15 R16
  end

  // pin drive, state report and input functions
  always_comb
  begin
    pin_prev_d = pin_in;
    oe_d = pbit(param_q, io_event_pkg::BIT_FUNCTION); // R14
    pin_d = event_any ~^ pbit(param_q, io_event_pkg::BIT_ACTIVATION); // R15 R17
    if (oe_d)
      state_d = event_any; // R10
    else
      state_d = pin_in ~^ pbit(param_q, io_event_pkg::BIT_ACTIVATION); // R09 R10
    stop_d = 1'b0;
    teach_d = 1'b0;
    rst_p_d = 1'b0;
    stopped_d = stopped_q;
    if (!oe_d && active_edge)
    begin
      case (infunc) // R16
        io_event_pkg::FUNC_STOPSTART:
        begin
          stop_d = 1'b1;
          stopped_d = !stopped_q;
        end
        io_event_pkg::FUNC_TEACH: teach_d = 1'b1;
        io_event_pkg::FUNC_RESET: rst_p_d = 1'b1;
        default: stop_d = 1'b0; // R09 no internal effect
      endcase
    end
    if (oe_d || infunc != io_event_pkg::FUNC_STOPSTART)
      stopped_d = 1'b0;
    valid_d = !pos_inv;
  end

  // apb slave: setup, access with one wait, done
  always_comb
  begin
    st_d = st_q;
    param_d = param_q;
    outdata_d = outdata_q;
    qual_d = qual_q;
    irq_mask_d = irq_mask_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    setup = psel_in && !penable_in;
    wr_ok = 1'b0;
    rd_status = 1'b0;
    case (st_q)
      ST_IDLE:
        if (setup)
          st_d = ST_ACCESS;
      ST_ACCESS:
      begin
        st_d = ST_DONE;
        prdata_d = 32'h0000_0000;
        case (paddr_in)
          io_event_pkg::ADDR_PARAM: prdata_d = param_q;
          io_event_pkg::ADDR_OUTDATA: prdata_d = {31'h0, outdata_q};
          io_event_pkg::ADDR_INDATA: prdata_d = {31'h0, state_q};
          io_event_pkg::ADDR_IRQ_STATUS:
          begin
            prdata_d = {29'h0, irq_st_q};
            rd_status = !pwrite_in;
          end
          io_event_pkg::ADDR_IRQ_MASK: prdata_d = {29'h0, irq_mask_q};
          io_event_pkg::ADDR_QUALITY: prdata_d = {16'h0, qual_q};
          default: pslverr_d = 1'b1;
        endcase
        wr_ok = pwrite_in && !pslverr_d;
        if (wr_ok)
        begin
          case (paddr_in)
            io_event_pkg::ADDR_PARAM: param_d = {6'h0, pwdata_in[25:24], 6'h0,
              pwdata_in[17:16], 1'b0, pwdata_in[14:11], 9'h0, pwdata_in[1:0]};
            io_event_pkg::ADDR_OUTDATA: outdata_d = pwdata_in[0];
            io_event_pkg::ADDR_IRQ_MASK: irq_mask_d = pwdata_in[2:0];
            io_event_pkg::ADDR_QUALITY: qual_d = pwdata_in[15:0];
            default: wr_ok = 1'b0;
          endcase
        end
      end
      ST_DONE:
        st_d = setup ? ST_ACCESS : ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
    pready_d = (st_d == ST_DONE); // ready stands for the done cycle only
  end

  // sticky interrupt status, read clears, set wins
  always_comb
  begin
    irq_st_d = rd_status ? 3'h0 : irq_st_q;
    if (oe_q && !pin_q && (pin_d != pin_q))
      irq_st_d[io_event_pkg::IRQ_PIN_RISE] = 1'b1;
    if (stop_d || teach_d || rst_p_d)
      irq_st_d[io_event_pkg::IRQ_TRIGGER] = 1'b1;
    if (valid_d && !valid_q)
      irq_st_d[io_event_pkg::IRQ_VALID] = 1'b1;
    irq_d = |(irq_st_d & irq_mask_d);
  end

  // register all state
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q <= ST_IDLE;
      param_q <= io_event_pkg::PARAM_RESET;
      outdata_q <= 1'b0;
      qual_q <= {io_event_pkg::QUALITY_ERR_RESET, io_event_pkg::QUALITY_WARN_RESET};
      irq_st_q <= 3'h0;
      irq_mask_q <= 3'h0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      pready_q <= 1'b0;
      pin_prev_q <= 1'b0;
      pin_q <= 1'b0;
      oe_q <= 1'b0;
      state_q <= 1'b0;
      stop_q <= 1'b0;
      teach_q <= 1'b0;
      rst_p_q <= 1'b0;
      stopped_q <= 1'b0;
      valid_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else if (ce_in)
    begin
      st_q <= st_d;
      param_q <= param_d;
      outdata_q <= outdata_d;
      qual_q <= qual_d;
      irq_st_q <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      pready_q <= pready_d;
      pin_prev_q <= pin_prev_d;
      pin_q <= pin_d;
      oe_q <= oe_d;
      state_q <= state_d;
      stop_q <= stop_d;
      teach_q <= teach_d;
      rst_p_q <= rst_p_d;
      stopped_q <= stopped_d;
      valid_q <= valid_d;
      irq_q <= irq_d;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign pin_out = pin_q;
  assign pin_oe_out = oe_q;
  assign meas_stop_out = stop_q;
  assign teach_preset_out = teach_q;
  assign reset_preset_out = rst_p_q;
  assign meas_valid_out = valid_q;
  assign irq_out = irq_q;

  // assertions
  sequence s_dev_fault_on;
    ce_in && pbit(param_q, io_event_pkg::BIT_EN_DEVERR) && device_fault_in && oe_d;
  endsequence

  a_fault_drives_pin: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R07
    s_dev_fault_on |=> pin_q == pbit(param_q, io_event_pkg::BIT_ACTIVATION))
    else $error("device fault did not drive pin");
  a_direct_follows: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R06
    ce_in && param_q[16] && param_q[0] && outdata_q |=> state_q)
    else $error("direct control not followed");
  a_no_event_idle: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R01
    ce_in && !event_any && oe_d |=> !state_q)
    else $error("pin active with no event");
  a_mode_oe: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R14
    ce_in |=> pin_oe_out == $past(param_q[0]))
    else $error("oe not following mode bit");
  a_teach_edge: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R16
    teach_preset_out |-> $past(infunc) == io_event_pkg::FUNC_TEACH && !$past(oe_d))
    else $error("teach without input edge");
  a_pos_warn: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R04
    ce_in && oe_d && param_q[13] && quality_in < qual_q[7:0] |=> state_q)
    else $error("warning threshold ignored");
  a_laser_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R12
    ce_in && restart |=> !meas_valid_out [*2])
    else $error("valid too early after restart");
  a_func_none: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R09
    ce_in && infunc == io_event_pkg::FUNC_NONE |=> !meas_stop_out && !teach_preset_out)
    else $error("function none had effect");
endmodule

// file: bench/ctrl_model.sv
// apb controller model issuing parameter and process data transfers
`timescale 1ns/1ps
module ctrl_model (
  input wire logic clk_sys_in,
  input wire logic pready_in,
  output logic psel_out = 1'b0,
  output logic penable_out = 1'b0,
  output logic pwrite_out = 1'b0,
  output logic [7:0] paddr_out = 8'h0,
  output logic [31:0] pwdata_out = 32'h0,
  output logic stall_out = 1'b0
);
  // one transfer: setup, access held until pready, then release
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_sys_in);
    penable_out <= 1'b1;
    @(posedge clk_sys_in);
    while (pready_in !== 1'b1 && n < 64)
    begin
      @(posedge clk_sys_in);
      n++;
    end
    stall_out <= (n >= 64);
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // released lines show no stale value
    paddr_out <= ~a;
    pwdata_out <= ~d;
  endtask
endmodule

// file: bench/configurable_io_event_port_tb.sv
// self-checking bench for the configurable io event port
`timescale 1ns/1ps
module configurable_io_event_port_tb;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, stall, pin_out, pin_oe;
  logic m_stop, m_teach, m_reset, m_valid, irq;
  logic pin_in = 1'b0;
  logic ce = 1'b1;
  logic pos_inv = 1'b0;
  logic spd_inv = 1'b0;
  logic fault = 1'b0;
  logic laser = 1'b0;
  logic wake = 1'b0;
  logic [7:0] paddr;
  logic [7:0] quality = 8'hff;
  logic [31:0] pwdata, prdata;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int errors = 0;
  int n_tests = 0;
  int seed = 81326;
  int cnt[3] = '{0, 0, 0};
  int b[3];
  int ebit[4] = '{io_event_pkg::BIT_EN_POS, io_event_pkg::BIT_EN_SPEED,
    io_event_pkg::BIT_EN_DEVERR, io_event_pkg::BIT_EN_DIRECT};
  int k, j, c;

  always #12.5 clk_sys_in = ~clk_sys_in;

  ctrl_model i_ctrl (.clk_sys_in(clk_sys_in), .pready_in(pready), .psel_out(psel),
    .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
    .stall_out(stall));

  io_event_port #(.LASER_CYC(20), .MOTOR_CYC(50)) i_dut (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .ce_in(ce), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe), .pos_raw_invalid_in(pos_inv), .speed_raw_invalid_in(spd_inv),
    .quality_in(quality), .device_fault_in(fault), .laser_on_in(laser),
    .standby_wake_in(wake), .meas_stop_out(m_stop), .teach_preset_out(m_teach),
    .reset_preset_out(m_reset), .meas_valid_out(m_valid), .irq_out(irq));

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    n_tests++;
    if (seen !== want)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic give_verdict();
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_ctrl.xfer(1'b1, a, d);
  endtask

  // x holds don't-care flag, expected slave error and expected data
  task automatic rd(input logic [7:0] a, input logic [33:0] x);
    exp_q.push_back(x);
    i_ctrl.xfer(1'b0, a, 32'h0);
  endtask

  task automatic set_src(input int s, input logic v);
    case (s)
      0: pos_inv <= v;
      1: spd_inv <= v;
      2: fault <= v;
      default: wr(io_event_pkg::ADDR_OUTDATA, {31'h0, v});
    endcase
  endtask

  // read answers are taken off the queue at the edge pready is seen
  always @(posedge clk_sys_in)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      e = exp_q.pop_front();
      if (!e[33]) check({pslverr, prdata}, e[32:0]);
    end
    cnt[0] += int'(m_stop);
    cnt[1] += int'(m_teach);
    cnt[2] += int'(m_reset);
    if (stall === 1'b1)
    begin
      errors++;
      give_verdict();
    end
  end

  // overall guard against a hang
  initial
  begin
    cyc(20000);
    errors++;
    give_verdict();
  end

  initial
  begin
    cyc(3);
    rst_in <= 1'b0;
    cyc(3);
    check(33'({pin_oe, pin_out}), 33'h2);
    rd(io_event_pkg::ADDR_PARAM, {2'b00, io_event_pkg::PARAM_RESET});
    rd(io_event_pkg::ADDR_QUALITY, {18'h0, io_event_pkg::QUALITY_ERR_RESET,
      io_event_pkg::QUALITY_WARN_RESET});
    rd(8'h3c, {2'b01, 32'h0});
    rd(io_event_pkg::ADDR_IRQ_STATUS, {2'b10, 32'h0});
    // each source alone, first with a foreign enable, then with its own
    for (k = 0; k < 4; k++)
    begin
      wr(io_event_pkg::ADDR_PARAM, 32'h3 | (32'h1 << ebit[(k + 1) % 4]));
      set_src(k, 1'b1);
      cyc(4);
      check(33'(pin_out), 33'h0);
      wr(io_event_pkg::ADDR_PARAM, 32'h3 | (32'h1 << ebit[k]));
      cyc(4);
      check(33'(pin_out), 33'h1);
      rd(io_event_pkg::ADDR_INDATA, {33'h0, 1'b1});
      set_src(k, 1'b0);
      cyc(4);
      check(33'(pin_out), 33'h0);
    end
    // active low output
    wr(io_event_pkg::ADDR_PARAM, 32'h1 | (32'h1 << io_event_pkg::BIT_EN_DEVERR));
    cyc(4);
    check(33'(pin_out), 33'h1);
    fault <= 1'b1;
    cyc(4);
    check(33'(pin_out), 33'h0);
    rd(io_event_pkg::ADDR_INDATA, {33'h0, 1'b1});
    fault <= 1'b0;
    // quality between thresholds, then below both
    quality <= 8'(8'h28 + $unsigned($random(seed)) % 40);
    wr(io_event_pkg::ADDR_PARAM, 32'h3 | (32'h1 << io_event_pkg::BIT_EN_WARN));
    cyc(4);
    check(33'(pin_out), 33'h1);
    wr(io_event_pkg::ADDR_PARAM, 32'h3 | (32'h1 << io_event_pkg::BIT_EN_ERR));
    cyc(4);
    check(33'(pin_out), 33'h0);
    quality <= 8'($unsigned($random(seed)) % 40);
    cyc(4);
    check(33'(pin_out), 33'h1);
    quality <= 8'hff;
    // input functions fire once per rising edge only
    wr(io_event_pkg::ADDR_IRQ_MASK, 32'h1 << io_event_pkg::IRQ_TRIGGER);
    // pin rises and a valid return are pending, no trigger yet
    rd(io_event_pkg::ADDR_IRQ_STATUS, {2'b00, 32'h5});
    for (c = 1; c < 4; c++)
    begin
      wr(io_event_pkg::ADDR_PARAM, 32'h2 | (32'(c) << io_event_pkg::POS_INFUNC));
      cyc(4);
      check(33'({pin_oe, irq}), 33'h0);
      b = cnt;
      pin_in <= 1'b1;
      cyc(4);
      pin_in <= 1'b0;
      cyc(4);
      for (j = 0; j < 3; j++)
        check(33'(cnt[j] - b[j]), 33'(j == c - 1));
      check(33'(irq), 33'h1);
      rd(io_event_pkg::ADDR_IRQ_STATUS, {2'b10, 32'h0});
    end
    // no function: level reported, nothing fired
    wr(io_event_pkg::ADDR_PARAM, 32'h2);
    b = cnt;
    pin_in <= 1'b1;
    cyc(4);
    rd(io_event_pkg::ADDR_INDATA, {33'h0, 1'b1});
    pin_in <= 1'b0;
    cyc(4);
    rd(io_event_pkg::ADDR_INDATA, {34'h0});
    check(33'(cnt[0] + cnt[1] + cnt[2] - b[0] - b[1] - b[2] + irq), 33'h0);
    // laser restart and standby wake hold values invalid
    wr(io_event_pkg::ADDR_PARAM, 32'h3);
    laser <= 1'b1;
    cyc(1);
    laser <= 1'b0;
    cyc(5);
    check(33'(m_valid), 33'h0);
    cyc(10);
    check(33'(m_valid), 33'h0);
    cyc(12);
    check(33'(m_valid), 33'h1);
    wake <= 1'b1;
    cyc(1);
    wake <= 1'b0;
    cyc(44);
    check(33'(m_valid), 33'h0);
    cyc(14);
    check(33'(m_valid), 33'h1);
    // both settle ends flagged a valid return
    rd(io_event_pkg::ADDR_IRQ_STATUS, {2'b00, 32'h4});
    // clock enable low freezes the pin until it returns
    wr(io_event_pkg::ADDR_PARAM, 32'h3 | (32'h1 << io_event_pkg::BIT_EN_DEVERR));
    cyc(2);
    ce <= 1'b0;
    fault <= 1'b1;
    cyc(4);
    check(33'(pin_out), 33'h0);
    ce <= 1'b1;
    cyc(4);
    check(33'(pin_out), 33'h1);
    fault <= 1'b0;
    cyc(4);
    give_verdict();
  end
endmodule
